// ---- ssi_pkg.sv ----
// Constants and carrier types of the serial channel status and interrupt block.
package ssi_pkg;

	// Register byte offsets on the APB.
	localparam logic [7:0] SSI_OFF_CTRL   = 8'h00;
	localparam logic [7:0] SSI_OFF_STAT   = 8'h04;
	localparam logic [7:0] SSI_OFF_TXBUF  = 8'h08;
	localparam logic [7:0] SSI_OFF_RXBUF  = 8'h0C;
	localparam logic [7:0] SSI_OFF_MSTOP  = 8'h10;

	// Control register field positions.
	localparam int SSI_CB_XMIT_ON   = 0;
	localparam int SSI_CB_RCV_ON    = 1;
	localparam int SSI_CB_TDONE_IE  = 2;
	localparam int SSI_CB_RX_IE     = 3;
	localparam int SSI_CB_TEMPTY_IE = 4;
	localparam int SSI_CB_SYNC      = 5;
	localparam int SSI_CB_LATCH     = 6;

	// Status register field positions.
	localparam int SSI_SB_TDONE  = 2;
	localparam int SSI_SB_PAR    = 3;
	localparam int SSI_SB_FRAME  = 4;
	localparam int SSI_SB_OVR    = 5;
	localparam int SSI_SB_RXFULL = 6;
	localparam int SSI_SB_TEMPTY = 7;

	// Reset values.
	localparam logic [6:0] SSI_CTRL_RST  = 7'h40;
	localparam logic       SSI_MSTOP_RST = 1'b1;
	localparam logic [7:0] SSI_BUF_RST   = 8'h00;

	// Index of the last data bit of a frame.
	localparam logic [2:0] SSI_LAST_BIT = 3'h7;

	// Encoded source of the highest pending request.
	localparam logic [2:0] SSI_SRC_NONE   = 3'h0;
	localparam logic [2:0] SSI_SRC_RXERR  = 3'h1;
	localparam logic [2:0] SSI_SRC_RXFULL = 3'h2;
	localparam logic [2:0] SSI_SRC_TEMPTY = 3'h3;
	localparam logic [2:0] SSI_SRC_TDONE  = 3'h4;

	// Control fields as a carrier.
	typedef struct packed {
		logic latch;
		logic sync;
		logic tempty_ie;
		logic rx_ie;
		logic tdone_ie;
		logic rcv_on;
		logic xmit_on;
	} ssi_ctrl_type;

	// Interrupt request outputs as a carrier.
	typedef struct packed {
		logic tx_done_irq;
		logic rx_err_irq;
		logic rx_full_irq;
		logic tx_empty_irq;
	} ssi_irq_type;

	// Frame result from the receive shifter.
	typedef struct packed {
		logic       frame_err;
		logic       parity_err;
		logic [7:0] data;
	} ssi_rxframe_type;

	// Transmit state machine.
	typedef enum logic [1:0] {
		SSI_TX_IDLE  = 2'b01,
		SSI_TX_SHIFT = 2'b10
	} ssi_txst_type;

endpackage

// ---- ssi_serial_channel.sv ----
// Status, interrupt and error logic of one serial channel with APB registers.
`timescale 1ns/1ps
`default_nettype none
module ssi_serial_channel
	import ssi_pkg::*;
(
	// Clock and reset.
	input  wire logic            pclk,
	input  wire logic            presetn,
	// APB slave.
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic [31:0]          prdata,
	output logic                 pready,
	output logic                 pslverr,
	// Shifter side, same clock.
	input  wire logic            bit_tick,
	input  wire logic            rx_done,
	input  wire ssi_rxframe_type rx_frame,
	output logic                 txd,
	// Transfer controller.
	input  wire logic            xfer_wr_tx,
	input  wire logic [7:0]      xfer_tx_data,
	input  wire logic            xfer_rd_rx,
	output logic [7:0]           xfer_rx_data,
	input  wire logic            xfer_irq_select,
	input  wire logic            xfer_count_zero,
	output logic                 xfer_tx_req,
	output logic                 xfer_rx_req,
	// Interrupt controller.
	output ssi_irq_type          irq,
	output logic [2:0]           irq_top
);

	////////////////////////////////////////////////////////////////////////
	// Storage.

	logic            mstop_ff;        // Module stop, set out of reset.
	ssi_ctrl_type    ctrl_ff;         // Control register.
	logic [7:0]      tx_buffer_ff;    // Transmit buffer.
	logic [7:0]      rx_buffer_ff;    // Receive buffer.
	logic [7:0]      tx_shift_ff;     // Transmit shift register.
	logic [2:0]      bit_cnt_ff;      // Bit being sent.
	ssi_txst_type    tx_st_ff;        // Transmit state.
	logic            line_ff;         // Serial output level while enabled.
	logic            temp_ff;         // Transmit buffer empty flag.
	logic            tdone_ff;        // Transmit done flag.
	logic            rfull_ff;        // Receive buffer full flag.
	logic            ovr_ff;          // Overrun fault flag.
	logic            frm_ff;          // Framing fault flag.
	logic            par_ff;          // Parity fault flag.
	logic [7:0]      armed_ff;        // Flags seen as 1 by a status read.
	logic [31:0]     prdata_ff;       // Read data captured in setup.
	logic            perr_ff;         // Error answer captured in setup.

	////////////////////////////////////////////////////////////////////////
	// Bus decode.

	wire logic setup_w  = psel & ~penable;
	wire logic access_w = psel & penable;
	wire logic hit_ctrl = (paddr == SSI_OFF_CTRL);
	wire logic hit_stat = (paddr == SSI_OFF_STAT);
	wire logic hit_txb  = (paddr == SSI_OFF_TXBUF);
	wire logic hit_rxb  = (paddr == SSI_OFF_RXBUF);
	wire logic hit_mst  = (paddr == SSI_OFF_MSTOP);
	// Channel registers answer only after module stop is released.
	wire logic chan_ok  = ~mstop_ff & (hit_ctrl | hit_stat | hit_txb | hit_rxb);
	wire logic bad_w    = ~(hit_mst | chan_ok);
	wire logic wr_w     = access_w & pwrite & ~bad_w;
	wire logic rd_w     = access_w & ~pwrite & ~bad_w;
	wire logic wr_ctrl  = wr_w & hit_ctrl;
	wire logic wr_stat  = wr_w & hit_stat;
	wire logic wr_txb   = wr_w & hit_txb;
	wire logic wr_mst   = wr_w & hit_mst;
	wire logic rd_stat  = rd_w & hit_stat;

	// Status word as software sees it.
	wire logic [7:0] stat_w = {temp_ff, rfull_ff, ovr_ff, frm_ff, par_ff, tdone_ff, 2'b00};

	// Read multiplexer, sampled in the setup cycle.
	wire logic [31:0] rmux_w =
		hit_mst  ? {31'h00000000, mstop_ff} :
		mstop_ff ? 32'h00000000 :
		hit_ctrl ? {25'h0000000, ctrl_ff} :
		hit_stat ? {24'h000000, stat_w} :
		hit_txb  ? {24'h000000, tx_buffer_ff} :
		hit_rxb  ? {24'h000000, rx_buffer_ff} : 32'h00000000;

	assign pready  = 1'b1;
	assign prdata  = prdata_ff;
	assign pslverr = access_w & perr_ff;

	// Capture read data and the error answer at the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h00000000;
			perr_ff   <= 1'b0;
		end else if (setup_w) begin
			prdata_ff <= pwrite ? 32'h00000000 : rmux_w;
			perr_ff   <= bad_w;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control, module stop and buffers.

	// Module stop and control; stop holds the other channel state, except the transmit shift register, in reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mstop_ff <= SSI_MSTOP_RST;
			ctrl_ff  <= SSI_CTRL_RST;
		end else begin
			if (wr_mst)
				mstop_ff <= pwdata[0];
			if (mstop_ff)
				ctrl_ff <= SSI_CTRL_RST;
			else if (wr_ctrl)
				ctrl_ff <= pwdata[6:0];
		end
	end

	// Software or controller write to the transmit buffer.
	wire logic [7:0] txw_data = wr_txb ? pwdata[7:0] : xfer_tx_data;
	wire logic       txw_w    = wr_txb | xfer_wr_tx;

	// Automatic clearing is withheld in this controller setting.
	wire logic auto_ok = ~(~xfer_irq_select & ~xfer_count_zero);

	// Transmit buffer accepts data at any time outside module stop, overwriting old data.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tx_buffer_ff <= SSI_BUF_RST;
		else if (mstop_ff)
			tx_buffer_ff <= SSI_BUF_RST;
		else if (txw_w)
			tx_buffer_ff <= txw_data;
	end

	assign xfer_rx_data = rx_buffer_ff;

	////////////////////////////////////////////////////////////////////////
	// Interlocks.

	wire logic any_fault = ovr_ff | frm_ff | par_ff;
	// Overrun halts both directions; in sync mode any fault does.
	wire logic halt_w = ovr_ff | (ctrl_ff.sync & any_fault);

	////////////////////////////////////////////////////////////////////////
	// Transmitter.

	wire logic tx_run   = ctrl_ff.xmit_on & ~mstop_ff;
	wire logic can_load = tx_run & ~temp_ff & ~halt_w;
	wire logic idle_w   = (tx_st_ff == SSI_TX_IDLE);
	wire logic at_last  = (bit_cnt_ff == SSI_LAST_BIT);
	// Bit 7 is entered on this tick.
	wire logic into_last = bit_tick & (tx_st_ff == SSI_TX_SHIFT) &
		(bit_cnt_ff == SSI_LAST_BIT - 3'h1);
	// Frame ends on this tick.
	wire logic frame_end = bit_tick & (tx_st_ff == SSI_TX_SHIFT) & at_last;
	// A word moves into the shift register.
	wire logic load_w = can_load & (idle_w | frame_end);

	// Transmit sequencer: load, shift LSB first, hold the last level.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_ff    <= SSI_TX_IDLE;
			tx_shift_ff <= SSI_BUF_RST;
			bit_cnt_ff  <= 3'h0;
			line_ff     <= 1'b1;
		end else if (!tx_run) begin
			// Disabling resets the transmitter at once.
			tx_st_ff   <= SSI_TX_IDLE;
			bit_cnt_ff <= 3'h0;
			line_ff    <= 1'b1;
		end else if (load_w) begin
			tx_st_ff    <= SSI_TX_SHIFT;
			tx_shift_ff <= tx_buffer_ff;
			bit_cnt_ff  <= 3'h0;
			line_ff     <= tx_buffer_ff[0];
		end else if (frame_end) begin
			// No new word: the line keeps the bit 7 level.
			tx_st_ff <= SSI_TX_IDLE;
		end else if (bit_tick && tx_st_ff == SSI_TX_SHIFT) begin
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			line_ff    <= tx_shift_ff[bit_cnt_ff + 3'h1];
		end
	end

	// Pin follows the port latch until the transmitter is enabled.
	assign txd = tx_run ? line_ff : ctrl_ff.latch;

	////////////////////////////////////////////////////////////////////////
	// Flag clearing by software.

	// A status write of 0 clears a flag only if a read saw it as 1.
	wire logic [7:0] swclr = {8{wr_stat}} & ~pwdata[7:0] & armed_ff;

	// Remember which flags a status read returned as 1.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			armed_ff <= 8'h00;
		else if (mstop_ff)
			armed_ff <= 8'h00;
		else if (rd_stat)
			armed_ff <= stat_w;
		else
			armed_ff <= armed_ff & ~swclr;
	end

	// Transmit-empty clears by software or by a controller write when automatic clearing is allowed.
	wire logic clr_temp = swclr[SSI_SB_TEMPTY] | (xfer_wr_tx & auto_ok);

	// Transmit flags; setting wins over a clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			temp_ff  <= 1'b1;
			tdone_ff <= 1'b1;
		end else if (!tx_run) begin
			temp_ff  <= 1'b1;
			tdone_ff <= 1'b1;
		end else begin
			if (load_w)
				temp_ff <= 1'b1;
			else if (clr_temp)
				temp_ff <= 1'b0;
			if (into_last && temp_ff)
				tdone_ff <= 1'b1;
			else if (clr_temp || swclr[SSI_SB_TDONE])
				tdone_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receiver.

	wire logic rx_take = rx_done & ctrl_ff.rcv_on & ~mstop_ff & ~halt_w;
	wire logic rx_ovr  = rx_take & rfull_ff;
	wire logic rx_bad  = rx_take & ~rfull_ff & (rx_frame.frame_err | rx_frame.parity_err);
	wire logic rx_good = rx_take & ~rfull_ff & ~rx_frame.frame_err & ~rx_frame.parity_err;
	wire logic clr_rful = swclr[SSI_SB_RXFULL] | (xfer_rd_rx & auto_ok);

	// Receive buffer: overrun discards the shifted word.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rx_buffer_ff <= SSI_BUF_RST;
		else if (mstop_ff)
			rx_buffer_ff <= SSI_BUF_RST;
		else if (rx_good || rx_bad)
			rx_buffer_ff <= rx_frame.data;
	end

	// Receive flags; only module stop or software clears faults.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rfull_ff <= 1'b0;
			ovr_ff   <= 1'b0;
			frm_ff   <= 1'b0;
			par_ff   <= 1'b0;
		end else if (mstop_ff) begin
			rfull_ff <= 1'b0;
			ovr_ff   <= 1'b0;
			frm_ff   <= 1'b0;
			par_ff   <= 1'b0;
		end else begin
			if (rx_good)
				rfull_ff <= 1'b1;
			else if (clr_rful)
				rfull_ff <= 1'b0;
			if (rx_ovr)
				ovr_ff <= 1'b1;
			else if (swclr[SSI_SB_OVR])
				ovr_ff <= 1'b0;
			// A break re-sets framing on every frame taken.
			if (rx_take && rx_frame.frame_err)
				frm_ff <= 1'b1;
			else if (swclr[SSI_SB_FRAME])
				frm_ff <= 1'b0;
			if (rx_take && rx_frame.parity_err)
				par_ff <= 1'b1;
			else if (swclr[SSI_SB_PAR])
				par_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt requests.

	// Four requests, each gated by an enable; rx_ie gates both receive requests.
	assign irq.tx_empty_irq = temp_ff & ctrl_ff.tempty_ie & tx_run;
	assign irq.tx_done_irq  = tdone_ff & ctrl_ff.tdone_ie & tx_run;
	assign irq.rx_full_irq  = rfull_ff & ctrl_ff.rx_ie;
	assign irq.rx_err_irq   = any_fault & ctrl_ff.rx_ie;

	// Only these two requests may start the transfer controller.
	assign xfer_tx_req = irq.tx_empty_irq;
	assign xfer_rx_req = irq.rx_full_irq;

	// Highest pending source of this channel in default order.
	assign irq_top = irq.rx_err_irq   ? SSI_SRC_RXERR :
	                 irq.rx_full_irq  ? SSI_SRC_RXFULL :
	                 irq.tx_empty_irq ? SSI_SRC_TEMPTY :
	                 irq.tx_done_irq  ? SSI_SRC_TDONE : SSI_SRC_NONE;

	////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Overrun keeps the full flag and the old buffer contents.
	a_ovr_keeps_buf: assert property (rx_ovr |=> rfull_ff && ovr_ff && $stable(rx_buffer_ff))
		else $error("overrun changed receive buffer");
	// A faulty frame without overrun is stored but not flagged full.
	a_fault_no_full: assert property (rx_bad |=> !rfull_ff && rx_buffer_ff == $past(rx_frame.data))
		else $error("faulty frame handled wrongly");
	// Sync mode never loads a word while a fault is pending.
	a_sync_tx_block: assert property (ctrl_ff.sync && any_fault |-> !load_w)
		else $error("transmit started with fault pending");
	// An overrun freezes reception until software clears it.
	a_ovr_halts_rx: assert property (ovr_ff && rx_done |=> $stable(rx_buffer_ff) && $stable(rfull_ff))
		else $error("receive continued during overrun");
	// The done flag drops no later than the empty flag.
	a_done_with_empty: assert property ($fell(temp_ff) |-> !tdone_ff)
		else $error("done flag outlived empty flag");
	// A suppressed controller write never clears the empty flag.
	a_auto_clr_held: assert property (xfer_wr_tx && !xfer_irq_select && !xfer_count_zero
		&& !swclr[SSI_SB_TEMPTY] && tx_run |=> temp_ff == $past(temp_ff) || temp_ff)
		else $error("flag auto cleared while suppressed");
	// Each load refills the shifter and raises the empty flag.
	a_load_sets_empty: assert property (load_w |=> temp_ff && tx_shift_ff == $past(tx_buffer_ff))
		else $error("load did not set empty flag");
	// A disabled transmitter hands the pin to the port latch.
	a_pin_port: assert property (!tx_run |-> txd == ctrl_ff.latch)
		else $error("pin not following port latch");
	// Any fault raises the error request at top priority.
	a_err_irq: assert property (any_fault && ctrl_ff.rx_ie |-> irq.rx_err_irq && irq_top == SSI_SRC_RXERR)
		else $error("error request not top");
	// Module stop holds control and receive state at reset values.
	a_stop_holds: assert property (mstop_ff |=> ctrl_ff == SSI_CTRL_RST && !rfull_ff)
		else $error("channel active under stop");
	// A write of one to a flag leaves it set.
	a_w1_ignored: assert property (wr_stat && pwdata[SSI_SB_OVR] && ovr_ff |=> ovr_ff)
		else $error("write of one cleared a flag");

	// Flag precedence and request checks.
	// A new frame with a framing fault sets the flag again, even after a clear.
	a_break_refires: assert property (rx_take && rx_frame.frame_err |=> frm_ff)
		else $error("framing fault not set again");
	// Turning the receiver off leaves the fault flags as they were.
	a_rcv_off_keeps: assert property (wr_ctrl && !pwdata[SSI_CB_RCV_ON] && !rx_take |=>
		$stable({ovr_ff, frm_ff, par_ff}))
		else $error("receiver disable changed fault flags");
	// Bit 7 entered with no new word waiting sets the done flag.
	a_done_set_wins: assert property (into_last && temp_ff |=> tdone_ff)
		else $error("done flag not set at last bit");
	// A controller write with automatic clearing allowed clears the empty flag unless a load sets it again.
	a_xfer_clears: assert property (xfer_wr_tx && auto_ok && tx_run && !load_w |=> !temp_ff)
		else $error("controller write left empty flag set");
	// A good frame raises the receive-full request towards the controller.
	a_rx_full_irq: assert property (rx_good && ctrl_ff.rx_ie && !wr_ctrl |=> xfer_rx_req)
		else $error("receive-full request missing");

	// Covers for the main scenarios.
	c_overrun: cover property (rx_ovr);
	c_done_at_end: cover property (into_last && temp_ff);
	c_back_to_back: cover property (frame_end && load_w);
	c_auto_clear: cover property (xfer_rd_rx && auto_ok && rfull_ff);
	c_break_again: cover property (rx_take && rx_frame.frame_err && frm_ff);

endmodule
`default_nettype wire

// ---- ssi_remote.sv ----
// Remote serial device model on the shifter side of the channel.
`timescale 1ns/1ps
`default_nettype none
module ssi_remote
	import ssi_pkg::*;
(
	// Clock and reset.
	input  wire logic            pclk,
	input  wire logic            presetn,
	// Line side.
	input  wire logic            txd,
	input  wire logic            tick_en,
	output var  logic            bit_tick,
	output var  logic            rx_done,
	output var  ssi_rxframe_type rx_frame,
	// Observed transmit byte and bit count.
	output var  logic [7:0]      cap,
	output var  logic [3:0]      tcnt
);
	logic [2:0] div_ff; // Divider that spaces the bit pulses.

	// The line is sampled at each bit pulse, before the channel moves to its next bit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff   <= 3'h0;
			bit_tick <= 1'b0;
			cap      <= 8'h00;
			tcnt     <= 4'h0;
		end else begin
			div_ff   <= tick_en ? div_ff + 3'h1 : 3'h0;
			bit_tick <= tick_en && (div_ff == 3'h7);
			if (bit_tick) begin
				cap  <= {txd, cap[7:1]};
				tcnt <= tcnt + 4'h1;
			end else if (!tick_en) begin
				tcnt <= 4'h0;
			end
		end
	end

	// Frame data is valid only with its pulse; otherwise the bus shows a changed pattern.
	initial begin
		rx_done  = 1'b0;
		rx_frame = 10'h155;
	end

	// Delivers one received frame with its fault bits.
	task automatic send(input logic [7:0] d, input logic fe, input logic pe);
		@(posedge pclk);
		rx_frame <= {fe, pe, d};
		rx_done  <= 1'b1;
		@(posedge pclk);
		rx_done  <= 1'b0;
		rx_frame <= ~{fe, pe, d};
		repeat (2) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking testbench of the serial channel status and interrupt block.
`timescale 1ns/1ps
`default_nettype none
module tb
	import ssi_pkg::*;
;
	logic            pclk = 1'b0;
	logic            presetn, psel, penable, pwrite, pready, pslverr, txd, err;
	logic            bit_tick, rx_done, xwr, xrd, xsel, xcz, xtreq, xrreq, tick_en;
	logic [7:0]      paddr, xtd, xrdata, cap;
	logic [31:0]     pwdata, prdata, rd;
	logic [3:0]      tcnt;
	logic [2:0]      irq_top;
	ssi_rxframe_type rx_frame;
	ssi_irq_type     irq;
	int              error_cnt = 0;
	int              comparisons = 0;

	always #12.5 pclk = ~pclk;

	ssi_serial_channel ssi_serial_channel_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bit_tick(bit_tick), .rx_done(rx_done),
		.rx_frame(rx_frame), .txd(txd), .xfer_wr_tx(xwr), .xfer_tx_data(xtd),
		.xfer_rd_rx(xrd), .xfer_rx_data(xrdata), .xfer_irq_select(xsel),
		.xfer_count_zero(xcz), .xfer_tx_req(xtreq), .xfer_rx_req(xrreq), .irq(irq),
		.irq_top(irq_top));

	ssi_remote ssi_remote_inst (.pclk(pclk), .presetn(presetn), .txd(txd), .tick_en(tick_en),
		.bit_tick(bit_tick), .rx_done(rx_done), .rx_frame(rx_frame), .cap(cap), .tcnt(tcnt));

	////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then ends the run.
	task automatic close_out(input logic hung);
		if (hung) error_cnt++;
		$display("Counts: %0d compares, %0d mismatches", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Compares one result and counts a mismatch.
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) close_out(1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// One more edge, so that what a write changed is settled when the caller looks.
		@(posedge pclk);
	endtask

	// Reads a register and compares the masked value.
	task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask

	// Clears status bits by reading them first, then writing zero to them.
	task automatic clr(input logic [31:0] m);
		apb(1'b0, SSI_OFF_STAT, 32'h0);
		apb(1'b1, SSI_OFF_STAT, 32'hFF & ~m);
	endtask

	// One-cycle transfer controller access, write when tx is set.
	task automatic xpulse(input logic tx);
		@(posedge pclk);
		if (tx) xwr <= 1'b1;
		else xrd <= 1'b1;
		@(posedge pclk);
		xwr <= 1'b0;
		xrd <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	////////////////////////////////////////////////////////////
	// Module stop gates the registers; reset values after release.
	task automatic t_stop();
		apb(1'b0, SSI_OFF_CTRL, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		apb(1'b1, SSI_OFF_CTRL, 32'h55);
		apb(1'b1, SSI_OFF_MSTOP, 32'h0);
		rdm(SSI_OFF_CTRL, 32'hFF, {25'h0, SSI_CTRL_RST});
		rdm(SSI_OFF_STAT, 32'hFF, 32'h84);
		apb(1'b0, 8'h14, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("test stop done");
	endtask

	// Full buffer, overrun with faults, controller clear and halted reception.
	task automatic t_rx();
		apb(1'b1, SSI_OFF_CTRL, 32'h4A);
		ssi_remote_inst.send(8'hA5, 1'b0, 1'b0);
		chk({29'h0, irq.rx_full_irq, xrreq, irq.rx_err_irq}, 32'h6);
		chk({29'h0, irq_top}, {29'h0, SSI_SRC_RXFULL});
		ssi_remote_inst.send(8'h3C, 1'b1, 1'b1);
		chk({29'h0, irq_top}, {29'h0, SSI_SRC_RXERR});
		rdm(SSI_OFF_RXBUF, 32'hFF, 32'hA5);
		rdm(SSI_OFF_STAT, 32'h78, 32'h78);
		apb(1'b1, SSI_OFF_STAT, 32'hFF);
		rdm(SSI_OFF_STAT, 32'h20, 32'h20);
		xsel <= 1'b0;
		xcz  <= 1'b0;
		xpulse(1'b0);
		chk({24'h0, xrdata}, 32'hA5);
		rdm(SSI_OFF_STAT, 32'h40, 32'h40);
		xsel <= 1'b1;
		xpulse(1'b0);
		rdm(SSI_OFF_STAT, 32'h40, 32'h00);
		ssi_remote_inst.send(8'h77, 1'b0, 1'b0);
		rdm(SSI_OFF_RXBUF, 32'hFF, 32'hA5);
		clr(32'h38);
		rdm(SSI_OFF_STAT, 32'h78, 32'h00);
		ssi_remote_inst.send(8'h77, 1'b0, 1'b0);
		rdm(SSI_OFF_RXBUF, 32'hFF, 32'h77);
		xpulse(1'b0);
		$display("test rx done");
	endtask

	// Faults without overrun, break, receiver off and the sync interlock.
	task automatic t_fault();
		ssi_remote_inst.send(8'h5A, 1'b1, 1'b1);
		chk({30'h0, irq.rx_err_irq, xrreq}, 32'h2);
		rdm(SSI_OFF_RXBUF, 32'hFF, 32'h5A);
		rdm(SSI_OFF_STAT, 32'h78, 32'h18);
		clr(32'h10);
		ssi_remote_inst.send(8'h00, 1'b1, 1'b0);
		rdm(SSI_OFF_STAT, 32'h10, 32'h10);
		apb(1'b1, SSI_OFF_CTRL, 32'h40);
		rdm(SSI_OFF_STAT, 32'h18, 32'h18);
		apb(1'b1, SSI_OFF_CTRL, 32'h61);
		xtd <= 8'h11;
		xpulse(1'b1);
		rdm(SSI_OFF_STAT, 32'h80, 32'h00);
		clr(32'h18);
		rdm(SSI_OFF_STAT, 32'h80, 32'h80);
		apb(1'b1, SSI_OFF_CTRL, 32'h40);
		$display("test fault done");
	endtask

	// Software-driven frame, end of frame and controller writes.
	task automatic t_tx();
		int i;
		apb(1'b1, SSI_OFF_CTRL, 32'h55);
		chk({27'h0, irq, xtreq}, 32'h13);
		chk({29'h0, irq_top}, {29'h0, SSI_SRC_TEMPTY});
		rdm(SSI_OFF_STAT, 32'h80, 32'h80);
		apb(1'b1, SSI_OFF_TXBUF, 32'hC3);
		clr(32'h80);
		rdm(SSI_OFF_STAT, 32'h84, 32'h80);
		tick_en <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge pclk);
			if (tcnt == 4'h8) break;
		end
		tick_en <= 1'b0;
		if (i == 200) close_out(1'b1);
		chk({24'h0, cap}, 32'hC3);
		chk({30'h0, txd, irq.tx_done_irq}, 32'h3);
		xcz <= 1'b0;
		xsel <= 1'b0;
		xtd <= 8'h97;
		xpulse(1'b1);
		rdm(SSI_OFF_STAT, 32'h84, 32'h84);
		xcz <= 1'b1;
		xpulse(1'b1);
		rdm(SSI_OFF_STAT, 32'h84, 32'h80);
		chk({31'h0, txd}, 32'h1);
		$display("test tx done");
	endtask

	// Next word written and flagged before bit 7 keeps frames back to back.
	task automatic t_cont();
		int i;
		apb(1'b1, SSI_OFF_TXBUF, 32'h5E);
		clr(32'h80);
		tick_en <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge pclk);
			if (tcnt == 4'h8) break;
		end
		if (i == 200) close_out(1'b1);
		chk({23'h0, cap, irq.tx_done_irq}, {23'h0, 8'h97, 1'b0});
		for (i = 0; i < 200; i++) begin
			@(posedge pclk);
			if (tcnt == 4'h0) break;
		end
		tick_en <= 1'b0;
		if (i == 200) close_out(1'b1);
		chk({23'h0, cap, txd}, {23'h0, 8'h5E, 1'b0});
		chk({31'h0, irq.tx_done_irq}, 32'h1);
		$display("test cont done");
	endtask

	// Break through the port latch and disabled transmitter.
	task automatic t_pin();
		apb(1'b1, SSI_OFF_CTRL, 32'h41);
		apb(1'b1, SSI_OFF_CTRL, 32'h01);
		apb(1'b1, SSI_OFF_CTRL, 32'h00);
		chk({31'h0, txd}, 32'h0);
		rdm(SSI_OFF_STAT, 32'h84, 32'h84);
		apb(1'b1, SSI_OFF_CTRL, 32'h40);
		chk({31'h0, txd}, 32'h1);
		$display("test pin done");
	endtask

	////////////////////////////////////////////////////////////
	// Resets the block, then runs each scenario in turn.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		xwr = 1'b0;
		xrd = 1'b0;
		xsel = 1'b1;
		xcz = 1'b0;
		xtd = 8'h00;
		tick_en = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_stop();
		t_rx();
		t_fault();
		t_tx();
		t_cont();
		t_pin();
		close_out(1'b0);
	end
endmodule
`default_nettype wire
